// *** design/dmpd_top.sv ***
// Purpose: Mode parameter register bank and decode for a disk controller
// Assumes: Classic Wishbone slave, single 250 MHz clock, synchronous reset
// Notes:   Decoded controls feed the command engine, which lives elsewhere
//
// Overview of operation
// - Sector bit picks hard or soft sector
// - Modulation bit: one NRZ, zero MFM
// - Interface bit picks SMD bus or stepping
// - Pad byte 4E or 00 after fields
// - ID always CRC; data ECC or CRC
// - ECC four bytes, fixed polynomial, zero preset
// - Polynomial bit picks CRC generator
// - CRC preset follows initial-value bit
// - Auto correct only with ECC, 256; gated here by ECC only
// - Transfer bit: DMA or stop at buffers
// - Burst bit picks burst or cycle steal
// - Mask bits suppress status interrupt sources
// - Exclude bit: mark span, pad length
// - Normal seek waits for seek end
// - Parallel seek ends without seek end
// - Normal seek step low width formula
// - Parallel seek step low width formula
// - SMD controls only during read commands
// - Servo offset minus and plus outputs
// - Late and early strobe outputs
// - Unit bitmap marks present drives
// - CRC preset 0000 or FFFF
`timescale 1ns/10ps

module dmpd_top
    import dmpd_pkg::*;
(
    input wire logic clk_i,                    // 250 MHz clock
    input wire logic rst_i,                    // Synchronous active high reset
    input wire logic cyc_i,                    // Wishbone cycle
    input wire logic stb_i,                    // Wishbone strobe
    input wire logic we_i,                     // Wishbone write enable
    input wire logic [3:0] adr_i,              // Byte address
    input wire logic [3:0] sel_i,              // Byte lanes
    input wire logic [31:0] dat_i,             // Write data
    output logic [31:0] dat_o,                 // Read data
    output logic ack_o,                        // Acknowledge
    input wire logic read_cmd_i,               // Engine runs a read command
    input wire logic write_cmd_i,              // Engine runs a write command
    input wire logic seek_cmd_i,               // Engine runs seek or recalibrate
    input wire logic [7:0] status_i,           // Engine status register
    output logic irq_o,                        // Interrupt request, active high
    output dmpd_format_s format_o,             // Decoded disk format controls
    output dmpd_xfer_s xfer_o,                 // Decoded transfer and seek controls
    output logic servo_offset_minus_o,         // SMD head offset outward
    output logic servo_offset_plus_o,          // SMD head offset inward
    output logic late_strobe_o,                // SMD late strobe request
    output logic early_strobe_o,               // SMD early strobe request
    output logic [7:0] connected_drive_map_o,  // Present drives
    output logic config_error_o                // Prohibited combination loaded
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] format_mode_config;      // Format and check code bits
    logic [7:0] transfer_irq_seek_config; // Transfer, masks, seek bits
    logic [7:0] step_low_or_drive_ctrl;  // Step low code or SMD controls
    logic [7:0] connected_drive_map;     // Drive bitmap
    logic [7:0] next_format_mode_config;
    logic [7:0] next_transfer_irq_seek_config;
    logic [7:0] next_step_low_or_drive_ctrl;
    logic [7:0] next_connected_drive_map;
    logic ack;                           // Registered acknowledge
    logic next_ack;
    logic [31:0] rdata;                  // Registered read data
    logic [31:0] next_rdata;
    logic req;                           // New bus request this cycle
    logic wr_lane0;                      // Write touching the low byte

    assign req = cyc_i & stb_i & ~ack;
    assign wr_lane0 = req & we_i & sel_i[0];

    // ----------------------------------------------------------------
    // Bus next state
    // ----------------------------------------------------------------
    // Registers are write-only in the device, but reading back is handy
    // for software and test, so they read their held value.
    always_comb begin
        next_format_mode_config = format_mode_config;
        next_transfer_irq_seek_config = transfer_irq_seek_config;
        next_step_low_or_drive_ctrl = step_low_or_drive_ctrl;
        next_connected_drive_map = connected_drive_map;
        next_ack = req;
        next_rdata = rdata;
        if (wr_lane0) begin
            case (adr_i)
                DMPD_OFS_FORMAT: next_format_mode_config = dat_i[7:0];
                DMPD_OFS_XFER: next_transfer_irq_seek_config = dat_i[7:0];
                DMPD_OFS_STEP: next_step_low_or_drive_ctrl = dat_i[7:0];
                DMPD_OFS_UNITS: next_connected_drive_map = dat_i[7:0];
                default: begin
                    // Unmapped write is acknowledged and dropped
                end
            endcase
        end
        if (req && !we_i) begin
            case (adr_i)
                DMPD_OFS_FORMAT: next_rdata = {24'h000000, format_mode_config};
                DMPD_OFS_XFER: next_rdata = {24'h000000, transfer_irq_seek_config};
                DMPD_OFS_STEP: next_rdata = {24'h000000, step_low_or_drive_ctrl};
                DMPD_OFS_UNITS: next_rdata = {24'h000000, connected_drive_map};
                default: next_rdata = 32'h00000000;  // Unmapped reads zero
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Bus registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            format_mode_config <= DMPD_RST_FORMAT;
            transfer_irq_seek_config <= DMPD_RST_XFER;
            step_low_or_drive_ctrl <= DMPD_RST_STEP;
            connected_drive_map <= DMPD_RST_UNITS;
            ack <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            format_mode_config <= next_format_mode_config;
            transfer_irq_seek_config <= next_transfer_irq_seek_config;
            step_low_or_drive_ctrl <= next_step_low_or_drive_ctrl;
            connected_drive_map <= next_connected_drive_map;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign ack_o = ack;
    assign dat_o = rdata;

    // ----------------------------------------------------------------
    // Decode next state
    // ----------------------------------------------------------------
    dmpd_format_s fmt;                   // Registered format decode
    dmpd_format_s next_fmt;
    dmpd_xfer_s xfr;                     // Registered transfer decode
    dmpd_xfer_s next_xfr;
    logic [3:0] drv;                     // Registered SMD controls
    logic [3:0] next_drv;
    logic irq;
    logic next_irq;
    logic cfg_err;
    logic next_cfg_err;
    logic [7:0] units;
    logic [7:0] next_units;
    logic [7:0] step_code;               // Step low code
    logic [18:0] step_code_ext;          // Code widened for arithmetic

    assign step_code = step_low_or_drive_ctrl;
    assign step_code_ext = {11'h000, step_code};

    // Decode is registered one cycle after the register, so a command
    // starting in the same cycle as a write sees the old setting.
    always_comb begin
        next_fmt = fmt;
        next_fmt.hard_sector = format_mode_config[DMPD_B_SECTOR];
        next_fmt.nrz_select = format_mode_config[DMPD_B_MODULATION];
        next_fmt.smd_select = format_mode_config[DMPD_B_IFACE];
        // Hard sector always pads with zero
        if (format_mode_config[DMPD_B_PAD] && !format_mode_config[DMPD_B_SECTOR]) begin
            next_fmt.pad_byte = DMPD_PAD_GAP;
        end else begin
            next_fmt.pad_byte = DMPD_PAD_ZERO;
        end
        next_fmt.ecc_select = format_mode_config[DMPD_B_CHECK];
        next_fmt.check_bytes = format_mode_config[DMPD_B_CHECK] ? DMPD_ECC_BYTES
                                                              : DMPD_CRC_BYTES;
        next_fmt.ecc_poly = DMPD_ECC_POLY;
        next_fmt.ecc_init = DMPD_ECC_INIT;
        next_fmt.crc_poly = format_mode_config[DMPD_B_POLY] ? DMPD_CRC_POLY_CCITT
                                                            : DMPD_CRC_POLY_PLAIN;
        next_fmt.crc_init = format_mode_config[DMPD_B_INIT] ? DMPD_CRC_INIT_ONES
                                                            : DMPD_CRC_INIT_ZERO;
        // Correction gated by ECC; length checked by the engine
        next_fmt.correct_enable = format_mode_config[DMPD_B_CORRECT]
                                  & format_mode_config[DMPD_B_CHECK];
        next_fmt.mark_exclude = transfer_irq_seek_config[DMPD_B_EXCLUDE];
        next_fmt.pad_length = transfer_irq_seek_config[DMPD_B_EXCLUDE] ? DMPD_PAD_LEN_EXCL
                                                                    : DMPD_PAD_LEN_INCL;

        next_xfr = xfr;
        // DMA or PIO; PIO leaves memory moves to the host
        next_xfr.dma_select = transfer_irq_seek_config[DMPD_B_DMA];
        next_xfr.burst_select = transfer_irq_seek_config[DMPD_B_BURST];
        next_xfr.parallel_seek = transfer_irq_seek_config[DMPD_B_PARALLEL];
        // Wait for seek end only in normal seek
        next_xfr.wait_seek_end = ~transfer_irq_seek_config[DMPD_B_PARALLEL];
        next_xfr.step_enable = ~format_mode_config[DMPD_B_IFACE];
        next_xfr.step_disabled = 1'b0;
        if (transfer_irq_seek_config[DMPD_B_PARALLEL]) begin
            if (step_code == 8'h00) begin
                next_xfr.step_low_clks = DMPD_PS_CODE0;
            end else if (step_code == DMPD_STEP_CODE_MAX) begin
                next_xfr.step_low_clks = DMPD_PS_FASTEST;
            end else begin
                next_xfr.step_low_clks = 19'(step_code_ext * DMPD_PS_STEP + DMPD_PS_BASE);
            end
        end else begin
            if (step_code == 8'h00) begin
                next_xfr.step_low_clks = DMPD_NS_CODE0;
            end else if (step_code == DMPD_STEP_CODE_MAX) begin
                next_xfr.step_low_clks = 19'h00000;
                next_xfr.step_disabled = 1'b1;
            end else begin
                next_xfr.step_low_clks =
                    19'((step_code_ext - 19'd1) * DMPD_NS_STEP + DMPD_NS_BASE);
            end
        end

        // SMD controls only in reads, low in writes and seeks
        if (format_mode_config[DMPD_B_IFACE] && read_cmd_i && !write_cmd_i && !seek_cmd_i) begin
            next_drv = step_low_or_drive_ctrl[3:0];
        end else begin
            next_drv = 4'h0;
        end

        next_irq = (status_i[DMPD_B_CMD_END] & ~transfer_irq_seek_config[DMPD_B_END_MASK])
                 | (status_i[DMPD_B_SEEK_END] & ~transfer_irq_seek_config[DMPD_B_SEEK_MASK])
                 | (status_i[DMPD_B_DRV_ERR] & ~transfer_irq_seek_config[DMPD_B_ERR_MASK]);

        // Step interface serves four drives only
        if (format_mode_config[DMPD_B_IFACE]) begin
            next_units = connected_drive_map;
        end else begin
            next_units = {4'h0, connected_drive_map[3:0]};
        end

        // Flag the combinations that software is told never to load
        next_cfg_err = (format_mode_config[DMPD_B_PAD] & format_mode_config[DMPD_B_SECTOR])
                     | (format_mode_config[DMPD_B_CORRECT] & ~format_mode_config[DMPD_B_CHECK])
                     | (format_mode_config[DMPD_B_IFACE] & (|step_low_or_drive_ctrl[7:4]));
    end

    // ----------------------------------------------------------------
    // Decode registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fmt <= '0;
            xfr <= '0;
            drv <= 4'h0;
            irq <= 1'b0;
            units <= 8'h00;
            cfg_err <= 1'b0;
        end else begin
            fmt <= next_fmt;
            xfr <= next_xfr;
            drv <= next_drv;
            irq <= next_irq;
            units <= next_units;
            cfg_err <= next_cfg_err;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign format_o = fmt;
    assign xfer_o = xfr;
    assign servo_offset_minus_o = drv[DMPD_B_OFFSET_MINUS];
    assign servo_offset_plus_o = drv[DMPD_B_OFFSET_PLUS];
    assign late_strobe_o = drv[DMPD_B_LATE];
    assign early_strobe_o = drv[DMPD_B_EARLY];
    assign irq_o = irq;
    assign connected_drive_map_o = units;
    assign config_error_o = cfg_err;

endmodule

// *** inc/dmpd_pkg.sv ***
// Purpose: Shared constants and carriers for the disk mode parameter decode block
// Assumes: Registers reached over classic Wishbone with 32-bit data words
// Notes:   Each offset, field position, reset value and timing count is named once here
package dmpd_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] DMPD_OFS_FORMAT = 4'h0;   // format_mode_config
    localparam logic [3:0] DMPD_OFS_XFER = 4'h4;     // transfer_irq_seek_config
    localparam logic [3:0] DMPD_OFS_STEP = 4'h8;     // step_low_or_drive_ctrl
    localparam logic [3:0] DMPD_OFS_UNITS = 4'hc;    // connected_drive_map

    // ----------------------------------------------------------------
    // Field positions, format_mode_config
    // ----------------------------------------------------------------
    localparam int DMPD_B_SECTOR = 7;     // 1 hard sector, 0 soft sector
    localparam int DMPD_B_MODULATION = 6; // 1 NRZ, 0 MFM
    localparam int DMPD_B_IFACE = 5;      // 1 SMD, 0 step-pulse interface
    localparam int DMPD_B_PAD = 4;        // Pad pattern select
    localparam int DMPD_B_CHECK = 3;      // 1 ECC, 0 CRC on data area
    localparam int DMPD_B_POLY = 2;       // CRC polynomial select
    localparam int DMPD_B_INIT = 1;       // CRC initial value select
    localparam int DMPD_B_CORRECT = 0;    // Auto correct enable

    // ----------------------------------------------------------------
    // Field positions, transfer_irq_seek_config
    // ----------------------------------------------------------------
    localparam int DMPD_B_DMA = 7;        // 1 DMA, 0 PIO
    localparam int DMPD_B_BURST = 6;      // 1 burst, 0 cycle steal
    localparam int DMPD_B_END_MASK = 5;   // Command end mask
    localparam int DMPD_B_SEEK_MASK = 4;  // Seek end mask
    localparam int DMPD_B_ERR_MASK = 3;   // Drive error mask
    localparam int DMPD_B_EXCLUDE = 1;    // Mark exclude
    localparam int DMPD_B_PARALLEL = 0;   // Parallel seek

    // ----------------------------------------------------------------
    // Field positions, SMD drive control (low nibble of step register)
    // ----------------------------------------------------------------
    localparam int DMPD_B_OFFSET_MINUS = 3;
    localparam int DMPD_B_OFFSET_PLUS = 2;
    localparam int DMPD_B_LATE = 1;
    localparam int DMPD_B_EARLY = 0;

    // ----------------------------------------------------------------
    // Status bit positions gated by the masks
    // ----------------------------------------------------------------
    localparam int DMPD_B_CMD_END = 5;
    localparam int DMPD_B_SEEK_END = 4;
    localparam int DMPD_B_DRV_ERR = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] DMPD_RST_FORMAT = 8'h00;
    localparam logic [7:0] DMPD_RST_XFER = 8'h00;
    localparam logic [7:0] DMPD_RST_STEP = 8'h00;
    localparam logic [7:0] DMPD_RST_UNITS = 8'h00;

    // ----------------------------------------------------------------
    // Pattern, code and timing constants
    // ----------------------------------------------------------------
    localparam logic [7:0] DMPD_PAD_GAP = 8'h4e;
    localparam logic [7:0] DMPD_PAD_ZERO = 8'h00;
    localparam logic [15:0] DMPD_CRC_INIT_ZERO = 16'h0000;
    localparam logic [15:0] DMPD_CRC_INIT_ONES = 16'hffff;
    localparam logic [15:0] DMPD_CRC_POLY_CCITT = 16'h1021;  // x16+x12+x5+1
    localparam logic [15:0] DMPD_CRC_POLY_PLAIN = 16'h0001;  // x16+1
    localparam logic [31:0] DMPD_ECC_POLY = 32'h00a00805;    // x32+x23+x21+x11+x2+1
    localparam logic [31:0] DMPD_ECC_INIT = 32'h00000000;
    localparam logic [2:0] DMPD_ECC_BYTES = 3'h4;
    localparam logic [2:0] DMPD_CRC_BYTES = 3'h2;
    localparam logic [1:0] DMPD_PAD_LEN_EXCL = 2'h2;
    localparam logic [1:0] DMPD_PAD_LEN_INCL = 2'h3;
    localparam logic [2:0] DMPD_REC_LEN_256 = 3'h1;
    localparam logic [7:0] DMPD_STEP_CODE_MAX = 8'hff;
    localparam logic [18:0] DMPD_NS_CODE0 = 19'd988;
    localparam logic [18:0] DMPD_NS_STEP = 19'd1280;
    localparam logic [18:0] DMPD_NS_BASE = 19'd2364;
    localparam logic [18:0] DMPD_PS_CODE0 = 19'd27;
    localparam logic [18:0] DMPD_PS_STEP = 19'd6;
    localparam logic [18:0] DMPD_PS_BASE = 19'd28;
    localparam logic [18:0] DMPD_PS_FASTEST = 19'd5;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic hard_sector;          // Sector organisation
        logic nrz_select;           // Modulation
        logic smd_select;           // Drive interface
        logic [7:0] pad_byte;       // Pad pattern to write
        logic [1:0] pad_length;     // Pad length in bytes
        logic ecc_select;           // Data area check code
        logic [2:0] check_bytes;    // Appended check bytes
        logic [15:0] crc_poly;      // CRC generator
        logic [15:0] crc_init;      // CRC preset
        logic [31:0] ecc_poly;      // ECC generator
        logic [31:0] ecc_init;      // ECC preset
        logic correct_enable;       // Auto correct active
        logic mark_exclude;         // Sync mark outside check span
    } dmpd_format_s;

    typedef struct packed {
        logic dma_select;           // DMA to memory
        logic burst_select;         // Burst versus cycle steal
        logic parallel_seek;        // Seek mode
        logic wait_seek_end;        // Seek ends on drive seek end
        logic step_enable;          // Step pulses issued
        logic step_disabled;        // Code disables stepping
        logic [18:0] step_low_clks; // Step low width in clocks
    } dmpd_xfer_s;

endpackage

// *** tb/dmpd_assertions.sv ***
// Purpose: Port assertions for the mode parameter decode block
// Assumes: One clock, synchronous reset, answer one edge after the take
// Notes:   Decode is sampled two edges after a write is taken
`timescale 1ns/10ps
module dmpd_checker import dmpd_pkg::*; (
    input wire logic clk_i, input wire logic rst_i, input wire logic cyc_i,
    input wire logic stb_i, input wire logic we_i, input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i, input wire logic [31:0] dat_i, input wire logic ack_o,
    input wire logic read_cmd_i, input wire logic [7:0] status_i, input wire logic irq_o,
    input wire dmpd_format_s format_o, input wire dmpd_xfer_s xfer_o,
    input wire logic servo_offset_minus_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Format write taken at this edge
    logic wf;
    assign wf = cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == DMPD_OFS_FORMAT;
    a_ack_pulse: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not one cycle");
    a_mod_sel: assert property (wf |-> ##2 format_o.nrz_select == $past(dat_i[6], 2))
        else $error("modulation wrong");
    a_pad_byte: assert property (wf |-> ##2 format_o.pad_byte ==
        ($past(dat_i[7] || !dat_i[4], 2) ? 8'h00 : 8'h4e)) else $error("pad wrong");
    a_check_len: assert property (wf |-> ##2 format_o.check_bytes ==
        ($past(dat_i[3], 2) ? 3'h4 : 3'h2)) else $error("check length wrong");
    a_crc_preset: assert property (wf |-> ##2 format_o.crc_init ==
        ($past(dat_i[1], 2) ? 16'hffff : 16'h0000)) else $error("crc preset wrong");
    a_irq_quiet: assert property ($past(status_i[5:3]) == 3'h0 |-> !irq_o)
        else $error("irq without event");
    a_seek_wait: assert property (!$past(rst_i) |->
        xfer_o.wait_seek_end == !xfer_o.parallel_seek) else $error("seek wait wrong");
    a_smd_idle: assert property (!$past(read_cmd_i) |-> !servo_offset_minus_o)
        else $error("offset outside read");
    c_fmt_write: cover property (wf);
    c_irq: cover property (irq_o);
    c_offset: cover property (servo_offset_minus_o);
endmodule
bind dmpd_top dmpd_checker i_dmpd_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
    .read_cmd_i(read_cmd_i), .status_i(status_i), .irq_o(irq_o), .format_o(format_o),
    .xfer_o(xfer_o), .servo_offset_minus_o(servo_offset_minus_o));

// *** tb/dmpd_drive_model.sv ***
// Purpose: Engine and drive side feeding command phases and status events
// Assumes: Bench picks one command class at a time
// Notes:   Outputs move only after an edge, as the real engine does
`timescale 1ns/10ps
module dmpd_drive_model (
    input wire logic clk_i, input wire logic rst_i, input wire logic [1:0] op_i,
    input wire logic [7:0] flags_i, output logic read_cmd_o, output logic write_cmd_o,
    output logic seek_cmd_o, output logic [7:0] status_o
);
    always_ff @(posedge clk_i) begin
        read_cmd_o <= !rst_i && op_i == 2'h1;
        write_cmd_o <= !rst_i && op_i == 2'h2;
        seek_cmd_o <= !rst_i && op_i == 2'h3;
        status_o <= rst_i ? 8'h00 : flags_i;
    end
endmodule

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the mode parameter decode block
// Assumes: Answers within 20 cycles
// Notes:   Each scenario drives and judges its own traffic
`timescale 1ns/10ps
module tb_top import dmpd_pkg::*; ;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0, dat_o, got;
    logic [7:0] flags = 8'h00, status_i, connected_drive_map_o;
    logic [1:0] op = 2'h0;
    logic ack_o, irq_o, read_cmd_i, write_cmd_i, seek_cmd_i, config_error_o;
    logic servo_offset_minus_o, servo_offset_plus_o, late_strobe_o, early_strobe_o;
    dmpd_format_s format_o;
    dmpd_xfer_s xfer_o;
    int failures = 0, comparisons = 0;
    dmpd_top i_dmpd_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .read_cmd_i(read_cmd_i), .write_cmd_i(write_cmd_i),
        .seek_cmd_i(seek_cmd_i), .status_i(status_i), .irq_o(irq_o), .format_o(format_o),
        .xfer_o(xfer_o), .servo_offset_minus_o(servo_offset_minus_o),
        .servo_offset_plus_o(servo_offset_plus_o), .late_strobe_o(late_strobe_o),
        .early_strobe_o(early_strobe_o), .connected_drive_map_o(connected_drive_map_o),
        .config_error_o(config_error_o));
    dmpd_drive_model i_dmpd_drive_model (.clk_i(clk_i), .rst_i(rst_i), .op_i(op),
        .flags_i(flags), .read_cmd_o(read_cmd_i), .write_cmd_o(write_cmd_i),
        .seek_cmd_o(seek_cmd_i), .status_o(status_i));
    initial forever #2 clk_i = ~clk_i;
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
        if (g !== e) failures++;
    endtask
    task automatic summarize();
        if (failures == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One classic cycle; idle edges after it let the decode settle
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
        for (int n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
        if (ack_o !== 1'b1) failures++;
        if (ack_o !== 1'b1) summarize();
        got = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_format();
        logic [7:0] v [4] = '{8'h00, 8'h5f, 8'ha4, 8'h91};
        foreach (v[i]) begin
            wb(1'b1, DMPD_OFS_XFER, v[i] & 8'h02);
            wb(1'b1, DMPD_OFS_FORMAT, v[i]);
            check("kind", v[i][7:5], {format_o.hard_sector,
                format_o.nrz_select, format_o.smd_select});
            check("pad", (v[i][4] && !v[i][7]) ? 8'h4e : 8'h00, format_o.pad_byte);
            check("ecc", 32'h00a00805, format_o.ecc_poly);
            check("poly", v[i][2] ? 16'h1021 : 16'h0001, format_o.crc_poly);
            check("init", v[i][1] ? 16'hffff : 16'h0000, format_o.crc_init);
            check("span", {v[i][3] ? 3'h4 : 3'h2, v[i][1] ? 2'h2 : 2'h3,
                v[i][0] & v[i][3]}, {format_o.check_bytes, format_o.pad_length,
                format_o.correct_enable});
            check("mark", {v[i][3], v[i][1]}, {format_o.ecc_select,
                format_o.mark_exclude});
            check("eccinit", 32'h0, format_o.ecc_init);
            check("cfgerr", (v[i][4] & v[i][7]) | (v[i][0] & !v[i][3]),
                config_error_o);
        end
    endtask
    task automatic t_seek();
        logic [27:0] t [8] = '{{1'b0, 8'h00, 19'd988}, {1'b0, 8'h01, 19'd2364},
            {1'b0, 8'hfe, 19'd326204}, {1'b0, 8'hff, 19'd0}, {1'b1, 8'h00, 19'd27},
            {1'b1, 8'h01, 19'd34}, {1'b1, 8'hfe, 19'd1552}, {1'b1, 8'hff, 19'd5}};
        wb(1'b1, DMPD_OFS_FORMAT, 8'h00);
        foreach (t[i]) begin
            wb(1'b1, DMPD_OFS_XFER, {7'h00, t[i][27]});
            wb(1'b1, DMPD_OFS_STEP, t[i][26:19]);
            check("step_low", t[i][18:0], xfer_o.step_low_clks);
            check("seek", {!t[i][27], t[i][27], 1'b1,
                t[i][27:19] == 9'h0ff}, {xfer_o.wait_seek_end, xfer_o.parallel_seek,
                xfer_o.step_enable, xfer_o.step_disabled});
        end
        wb(1'b0, DMPD_OFS_STEP, 8'h00);
        check("hold", 32'hff, got);
        wb(1'b0, 4'h1, 8'h00);
        check("unmapped", 32'h0, got);
    endtask
    task automatic t_irq();
        wb(1'b1, DMPD_OFS_XFER, 8'hc0);
        check("dma", 2'b11, {xfer_o.dma_select, xfer_o.burst_select});
        for (int b = 3; b < 6; b++) begin
            flags <= 8'h01 << b;
            wb(1'b1, DMPD_OFS_XFER, 8'h00);
            check("irq", 1'b1, irq_o);
            wb(1'b1, DMPD_OFS_XFER, 8'h01 << b);
            check("irqmask", 1'b0, irq_o);
        end
        flags <= 8'h00;
        check("pio", 2'b00, {xfer_o.dma_select, xfer_o.burst_select});
    endtask
    task automatic t_smd();
        wb(1'b1, DMPD_OFS_UNITS, 8'ha5);
        check("map", 8'h05, connected_drive_map_o);
        wb(1'b1, DMPD_OFS_FORMAT, 8'h20);
        check("map", 8'ha5, connected_drive_map_o);
        check("step", 1'b0, xfer_o.step_enable);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, DMPD_OFS_STEP, 8'h01 << k);
            for (int o = 1; o < 4; o++) begin
                op <= o[1:0];
                repeat (3) @(posedge clk_i);
                check("drv", o == 1 ? 4'h1 << k : 4'h0, {servo_offset_minus_o,
                    servo_offset_plus_o, late_strobe_o, early_strobe_o});
            end
        end
        wb(1'b1, DMPD_OFS_STEP, 8'h10);
        check("cfgerr", 1'b1, config_error_o);
    endtask
    // Mid-run reset: decode shows the zero registers two edges after release
    task automatic t_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("rstdec", {2'h3, 3'h2, 19'd988}, {format_o.pad_length,
            format_o.check_bytes, xfer_o.step_low_clks});
        wb(1'b0, DMPD_OFS_FORMAT, 8'h00);
        check("rstreg", 32'h0, got);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_format();
        t_seek();
        t_irq();
        t_smd();
        t_reset();
        summarize();
    end
endmodule
